// ===== hw/tcwu_top.sv
// Timer8 compare waveform unit: counter, channel A compare output, flags,
// pin override, Avalon-MM register slave.
// Assumes a single-master Avalon-MM bus on clk_sys_in, 32-bit data.
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module tcwu_top
   import tcwu_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic pin_out,
   output logic pin_oe_out,
   output logic overflow_flag_out,
   output logic channel_a_compare_flag_out
);
   import tcwu_pkg::*;

   tcwu_ctrl_t ctrl_q;
   tcwu_bus_state_t bus_q;
   logic [7:0] count_value_q;
   logic [7:0] compare_register_a_q;
   logic [7:0] cmp_buf_q;
   logic compare_output_bit_q;
   logic overflow_flag_q;
   logic channel_a_compare_flag_q;
   logic block_q;
   logic [9:0] presc_q;
   logic tick;
   logic is_pwm;
   logic [7:0] top_val;
   logic at_top;
   logic match;
   logic acc;
   logic wr_ctrl;
   logic wr_count;
   logic wr_cmpa;
   logic wr_stat;
   logic force_cmp;

   function automatic logic action_out(input logic [1:0] act, input logic cur);
      case (act)
         TCWU_COM_TOGGLE: action_out = ~cur;
         TCWU_COM_CLEAR: action_out = 1'b0;
         TCWU_COM_SET: action_out = 1'b1;
         default: action_out = cur;
      endcase
   endfunction : action_out

   // Bus: one wait cycle, then acknowledge
   assign acc = (avs_read_in | avs_write_in) && (bus_q == TCWU_BUS_ACK);
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) && !acc;

   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
         bus_q <= TCWU_BUS_IDLE;
      else
      begin
         case (bus_q)
            TCWU_BUS_IDLE:
               if (avs_read_in | avs_write_in)
                  bus_q <= TCWU_BUS_ACK;
            TCWU_BUS_ACK: bus_q <= TCWU_BUS_IDLE;
            default: bus_q <= TCWU_BUS_IDLE;
         endcase
      end
   end

   assign wr_ctrl = acc && avs_write_in && avs_address_in == TCWU_OFF_CTRL;
   assign wr_count = acc && avs_write_in && avs_address_in == TCWU_OFF_COUNT
      && avs_byteenable_in[0];
   assign wr_cmpa = acc && avs_write_in && avs_address_in == TCWU_OFF_CMPA
      && avs_byteenable_in[0];
   assign wr_stat = acc && avs_write_in && avs_address_in == TCWU_OFF_STAT
      && avs_byteenable_in[0];

   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
         avs_readdata_out <= 32'h00000000;
      // Loaded in the wait cycle so the data stand at the accepting edge
      else if (avs_read_in && bus_q == TCWU_BUS_IDLE)
      begin
         case (avs_address_in)
            TCWU_OFF_CTRL: avs_readdata_out <= {17'h0, ctrl_q.port_data,
               ctrl_q.pin_direction_bit, 1'b0, 2'h0,
               ctrl_q.channel_a_output_action, 1'b0,
               ctrl_q.clock_select_field, 1'b0, ctrl_q.waveform_select};
            TCWU_OFF_COUNT: avs_readdata_out <= {24'h000000, count_value_q};
            TCWU_OFF_CMPA: avs_readdata_out <= {24'h000000, cmp_buf_q};
            TCWU_OFF_STAT: avs_readdata_out <= {29'h0,
               compare_output_bit_q, channel_a_compare_flag_q,
               overflow_flag_q};
            default: avs_readdata_out <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         ctrl_q.waveform_select <= TCWU_RST_WGM;
         ctrl_q.clock_select_field <= TCWU_RST_CS;
         ctrl_q.channel_a_output_action <= TCWU_RST_COM;
         ctrl_q.pin_direction_bit <= 1'b0;
         ctrl_q.port_data <= 1'b0;
      end
      else if (wr_ctrl && avs_byteenable_in[0] && avs_byteenable_in[1])
      begin
         ctrl_q.waveform_select <= avs_writedata_in[TCWU_CTRL_WGM_LSB +: 3];
         ctrl_q.clock_select_field <= avs_writedata_in[TCWU_CTRL_CS_LSB +: 3];
         ctrl_q.channel_a_output_action <=
            avs_writedata_in[TCWU_CTRL_COM_LSB +: 2];
         ctrl_q.pin_direction_bit <= avs_writedata_in[TCWU_CTRL_DDR_BIT];
         ctrl_q.port_data <= avs_writedata_in[TCWU_CTRL_PORT_BIT];
      end
   end

   // Prescaler: tick is a one-cycle enable at sys clock / N
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in || ctrl_q.clock_select_field == TCWU_RST_CS)
         presc_q <= 10'h000;
      else
         presc_q <= presc_q + 10'h001;
   end

   // Tick spacing N sets the toggle period
   // Stopped when clock select is zero
   always_comb
   begin
      case (ctrl_q.clock_select_field)
         3'h1: tick = 1'b1;
         3'h2: tick = (presc_q & TCWU_DIV8) == TCWU_DIV8;
         3'h3: tick = (presc_q & TCWU_DIV32) == TCWU_DIV32;
         3'h4: tick = (presc_q & TCWU_DIV64) == TCWU_DIV64;
         3'h5: tick = (presc_q & TCWU_DIV128) == TCWU_DIV128;
         3'h6: tick = (presc_q & TCWU_DIV256) == TCWU_DIV256;
         3'h7: tick = presc_q == TCWU_DIV1024;
         default: tick = 1'b0;
      endcase
   end

   // Sequence chosen by waveform select alone
   assign is_pwm = ctrl_q.waveform_select == TCWU_WGM_FAST
      || ctrl_q.waveform_select == TCWU_WGM_FAST_A;
   // Top is MAX or compare A
   assign top_val = (ctrl_q.waveform_select == TCWU_WGM_FAST_A) ?
      compare_register_a_q : TCWU_MAX;
   assign at_top = count_value_q == top_val;
   // Match blocked for one tick after a count write
   assign match = tick && !block_q && count_value_q == compare_register_a_q;
   assign force_cmp = wr_ctrl && avs_byteenable_in[1] && !is_pwm
      && avs_writedata_in[TCWU_CTRL_FOC_BIT];

   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
         block_q <= 1'b0;
      else if (wr_count)
         block_q <= 1'b1;
      else if (tick)
         block_q <= 1'b0;
   end

   // Counter
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
         count_value_q <= TCWU_RST_BYTE;
      else if (wr_count)
         count_value_q <= avs_writedata_in[7:0];
      else if (tick)
      begin
         // Clear-on-match clears after equality with compare A
         if (ctrl_q.waveform_select == TCWU_WGM_CTC && match)
            count_value_q <= TCWU_BOTTOM;
         // Fast PWM clears the tick after top
         else if (is_pwm && at_top)
            count_value_q <= TCWU_BOTTOM;
         else
            count_value_q <= count_value_q + 8'h01;
      end
   end

   // Buffered, moved to active register at bottom in PWM
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         cmp_buf_q <= TCWU_RST_BYTE;
         compare_register_a_q <= TCWU_RST_BYTE;
      end
      else
      begin
         if (wr_cmpa)
            cmp_buf_q <= avs_writedata_in[7:0];
         if (!is_pwm && wr_cmpa)
            compare_register_a_q <= avs_writedata_in[7:0];
         else if (is_pwm && tick && at_top)
            compare_register_a_q <= cmp_buf_q;
      end
   end

   // Compare output bit
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
         compare_output_bit_q <= 1'b0;
      else if (force_cmp)
         compare_output_bit_q <= action_out(
            avs_writedata_in[TCWU_CTRL_COM_LSB +: 2], compare_output_bit_q);
      else if (is_pwm && tick && match)
      begin
         // Polarity from action two or three
         // Match beats bottom so compare MAX holds level under action two or three; toggle still flips at each match
         if (ctrl_q.channel_a_output_action == TCWU_COM_CLEAR)
            compare_output_bit_q <= 1'b0;
         else if (ctrl_q.channel_a_output_action == TCWU_COM_SET)
            compare_output_bit_q <= 1'b1;
         else
            compare_output_bit_q <= action_out(
               ctrl_q.channel_a_output_action, compare_output_bit_q);
      end
      else if (is_pwm && tick && at_top)
      begin
         if (ctrl_q.channel_a_output_action == TCWU_COM_CLEAR)
            compare_output_bit_q <= 1'b1;
         else if (ctrl_q.channel_a_output_action == TCWU_COM_SET)
            compare_output_bit_q <= 1'b0;
      end
      // Action read at the match itself
      else if (match)
         compare_output_bit_q <= action_out(
            ctrl_q.channel_a_output_action, compare_output_bit_q);
   end

   // Flags: hardware set wins over software write-one-to-clear
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         overflow_flag_q <= 1'b0;
         channel_a_compare_flag_q <= 1'b0;
      end
      else
      begin
         // Set as count becomes zero from MAX, or from compare A when top is compare A
         if (tick && !wr_count && (is_pwm ? at_top : count_value_q == TCWU_MAX))
            overflow_flag_q <= 1'b1;
         else if (wr_stat && avs_writedata_in[TCWU_STAT_TOV_BIT])
            overflow_flag_q <= 1'b0;
         if (match)
            channel_a_compare_flag_q <= 1'b1;
         else if (wr_stat && avs_writedata_in[TCWU_STAT_OCF_BIT])
            channel_a_compare_flag_q <= 1'b0;
      end
   end

   assign pin_out = (ctrl_q.channel_a_output_action != TCWU_COM_NONE) ?
      compare_output_bit_q : ctrl_q.port_data;
   assign pin_oe_out = ctrl_q.pin_direction_bit;
   assign overflow_flag_out = overflow_flag_q;
   assign channel_a_compare_flag_out = channel_a_compare_flag_q;

   // Assertions
   ovf_normal_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (tick && !wr_count && !is_pwm && count_value_q == TCWU_MAX)
      |=> overflow_flag_q && count_value_q == TCWU_BOTTOM)
      else $error("overflow not set at wrap");
   hold_none_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (ctrl_q.channel_a_output_action == TCWU_COM_NONE && !force_cmp)
      |=> $stable(compare_output_bit_q))
      else $error("output bit moved with no action");
   pin_mux_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (ctrl_q.channel_a_output_action != TCWU_COM_NONE)
      |-> pin_out == compare_output_bit_q)
      else $error("pin not from compare output");
   ctc_clear_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (ctrl_q.waveform_select == TCWU_WGM_CTC && match && !wr_count
      && !wr_ctrl) |=> count_value_q == TCWU_BOTTOM && channel_a_compare_flag_q)
      else $error("clear-on-match failed");
   stop_hold_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (ctrl_q.clock_select_field == TCWU_RST_CS && !wr_count && !wr_ctrl)
      |=> $stable(count_value_q))
      else $error("counter moved while stopped");
   block_match_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      wr_count |=> !match until_with tick)
      else $error("match not blocked after count write");
   force_flag_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (force_cmp && !match && !channel_a_compare_flag_q)
      |=> !channel_a_compare_flag_q)
      else $error("force set compare flag");
   pwm_bottom_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (is_pwm && tick && at_top && !match && !wr_count && !wr_ctrl
      && ctrl_q.channel_a_output_action == TCWU_COM_CLEAR)
      |=> compare_output_bit_q && count_value_q == TCWU_BOTTOM)
      else $error("fast PWM bottom set failed");
   cw_toggle_c: cover property (@(posedge clk_sys_in)
      ctrl_q.waveform_select == TCWU_WGM_CTC && match);
   cw_pwm_c: cover property (@(posedge clk_sys_in) is_pwm && tick && at_top);
   cw_force_c: cover property (@(posedge clk_sys_in) force_cmp);
endmodule : tcwu_top
`default_nettype wire

// ===== hw/tcwu_pkg.sv
// Package for the 8-bit timer compare waveform unit.
// Assumes one 200 MHz system clock; the timer tick comes from an internal prescaler.
package tcwu_pkg;
   localparam int unsigned TCWU_CLK_MHZ = 200;

   // Register byte offsets
   localparam logic [3:0] TCWU_OFF_CTRL = 4'h0;
   localparam logic [3:0] TCWU_OFF_COUNT = 4'h4;
   localparam logic [3:0] TCWU_OFF_CMPA = 4'h8;
   localparam logic [3:0] TCWU_OFF_STAT = 4'hC;

   // Control and status field positions
   localparam int unsigned TCWU_CTRL_WGM_LSB = 0;
   localparam int unsigned TCWU_CTRL_CS_LSB = 4;
   localparam int unsigned TCWU_CTRL_COM_LSB = 8;
   localparam int unsigned TCWU_CTRL_FOC_BIT = 12;
   localparam int unsigned TCWU_CTRL_DDR_BIT = 13;
   localparam int unsigned TCWU_CTRL_PORT_BIT = 14;
   localparam int unsigned TCWU_STAT_TOV_BIT = 0;
   localparam int unsigned TCWU_STAT_OCF_BIT = 1;
   localparam int unsigned TCWU_STAT_OC_BIT = 2;

   // Reset values and count limits
   localparam logic [7:0] TCWU_RST_BYTE = 8'h00;
   localparam logic [2:0] TCWU_RST_WGM = 3'h0;
   localparam logic [1:0] TCWU_RST_COM = 2'h0;
   localparam logic [2:0] TCWU_RST_CS = 3'h0;
   localparam logic [7:0] TCWU_MAX = 8'hFF;
   localparam logic [7:0] TCWU_BOTTOM = 8'h00;

   // Waveform select codes
   localparam logic [2:0] TCWU_WGM_NORMAL = 3'h0;
   localparam logic [2:0] TCWU_WGM_CTC = 3'h2;
   localparam logic [2:0] TCWU_WGM_FAST = 3'h3;
   localparam logic [2:0] TCWU_WGM_FAST_A = 3'h7;

   // Output action codes
   localparam logic [1:0] TCWU_COM_NONE = 2'h0;
   localparam logic [1:0] TCWU_COM_TOGGLE = 2'h1;
   localparam logic [1:0] TCWU_COM_CLEAR = 2'h2;
   localparam logic [1:0] TCWU_COM_SET = 2'h3;

   // Prescaler tap counts (divide by N)
   localparam logic [9:0] TCWU_DIV8 = 10'h007;
   localparam logic [9:0] TCWU_DIV32 = 10'h01F;
   localparam logic [9:0] TCWU_DIV64 = 10'h03F;
   localparam logic [9:0] TCWU_DIV128 = 10'h07F;
   localparam logic [9:0] TCWU_DIV256 = 10'h0FF;
   localparam logic [9:0] TCWU_DIV1024 = 10'h3FF;

   typedef struct packed {
      logic [2:0] waveform_select;
      logic [2:0] clock_select_field;
      logic [1:0] channel_a_output_action;
      logic pin_direction_bit;
      logic port_data;
   } tcwu_ctrl_t;

   typedef enum logic [1:0] {
      TCWU_BUS_IDLE = 2'b01,
      TCWU_BUS_ACK = 2'b10
   } tcwu_bus_state_t;
endpackage : tcwu_pkg

// ===== verif/tcwu_pin_model.sv
// Port pin model for the timer compare waveform unit.
// Assumes the pin value and its output enable come straight from the block.
`timescale 1ns/100ps
`default_nettype none
module tcwu_pin_model
(
   input wire logic pin_in,
   input wire logic pin_oe_in,
   output logic pad_out
);
   // Weak pull-up: a released pad reads high, never the last driven level
   assign pad_out = pin_oe_in ? pin_in : 1'h1;
endmodule : tcwu_pin_model
`default_nettype wire

// ===== verif/tcwu_tb.sv
// Self-checking bench for the timer compare waveform unit.
// Assumes tcwu_top on one 200 MHz clock and a pulled-up port pin model.
`timescale 1ns/100ps
`default_nettype none
module tcwu_tb;
   import tcwu_pkg::*;
   logic clk_sys_in = 1'h0;
   logic sys_rst_in = 1'h1;
   logic [3:0] adr = 4'h0;
   logic rd = 1'h0;
   logic wr = 1'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, rv;
   logic wait_req, pin, pin_oe, ovf, ocf, pad;
   int err_count = 0;
   int n_tests = 0;
   int nd [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
   logic [2:0] md [4] = '{3'h0, 3'h2, 3'h3, 3'h7};
   logic [1:0] fa [7] = '{2'h3, 2'h1, 2'h1, 2'h0, 2'h3, 2'h0, 2'h2};
   logic [6:0] ff = 7'h7D;
   logic [6:0] fx = 7'h33;
   logic [1:0] pa [4] = '{2'h2, 2'h3, 2'h2, 2'h1};
   logic [7:0] pt [4] = '{8'h40, 8'h40, 8'h00, 8'h09};
   int ph [4] = '{65, 191, 1, 10};
   int pl [4] = '{191, 65, 255, 10};

   tcwu_top tcwu_top_i (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdat), .avs_byteenable_in(4'hF),
      .avs_readdata_out(rdat), .avs_waitrequest_out(wait_req),
      .pin_out(pin), .pin_oe_out(pin_oe), .overflow_flag_out(ovf),
      .channel_a_compare_flag_out(ocf));
   tcwu_pin_model tcwu_pin_model_i (.pin_in(pin), .pin_oe_in(pin_oe),
      .pad_out(pad));

   initial
   begin
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Request held until waitrequest is sampled low; read data taken there
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      @(posedge clk_sys_in);
      adr <= a;
      wr <= w;
      rd <= !w;
      wdat <= d;
      // Only the watchdog ends a wait that never completes
      do
      begin
         @(posedge clk_sys_in);
      end
      while (wait_req !== 1'h0);
      rv = rdat;
      wr <= 1'h0;
      rd <= 1'h0;
   endtask : bus

   function automatic logic [31:0] ctl(input logic [2:0] m,
      input logic [2:0] c, input logic [1:0] a, input logic f,
      input logic dir, input logic p);
      ctl = 32'h0;
      ctl[TCWU_CTRL_WGM_LSB +: 3] = m;
      ctl[TCWU_CTRL_CS_LSB +: 3] = c;
      ctl[TCWU_CTRL_COM_LSB +: 2] = a;
      ctl[TCWU_CTRL_FOC_BIT] = f;
      ctl[TCWU_CTRL_DDR_BIT] = dir;
      ctl[TCWU_CTRL_PORT_BIT] = p;
   endfunction : ctl

   task automatic step();
      @(posedge clk_sys_in);
      #1;
   endtask : step

   // One full pad period: high time then low time, in clocks
   task automatic meas(output int hi, output int lo);
      int n;
      for (n = 0; pad !== 1'h0 && n < 9000; n++) step();
      for (n = 0; pad !== 1'h1 && n < 9000; n++) step();
      for (hi = 0; pad === 1'h1 && hi < 9000; hi++) step();
      for (lo = 0; pad === 1'h0 && lo < 9000; lo++) step();
   endtask : meas

   // Set up stopped in normal mode so compare A is written directly
   task automatic run(input logic [2:0] m, input logic [2:0] c,
      input logic [1:0] a, input logic [7:0] top, input logic [7:0] cnt);
      bus(1'h1, TCWU_OFF_CTRL, ctl(3'h0, 3'h0, 2'h0, 1'h0, 1'h1, 1'h0));
      bus(1'h1, TCWU_OFF_CMPA, {24'h0, top});
      bus(1'h1, TCWU_OFF_COUNT, {24'h0, cnt});
      bus(1'h1, TCWU_OFF_STAT, 32'h3);
      bus(1'h1, TCWU_OFF_CTRL, ctl(m, c, a, 1'h0, 1'h1, 1'h0));
   endtask : run

   initial
   begin
      repeat (100000) @(posedge clk_sys_in);
      err_count++;
      conclude();
   end

   initial
   begin
      int h, l, n;
      logic v;
      repeat (12) @(posedge clk_sys_in);
      sys_rst_in <= 1'h0;
      @(posedge clk_sys_in);
      chk({pin, pin_oe, ovf, ocf}, 32'h0);
      for (int i = 0; i < 16; i += 2)
      begin
         bus(1'h0, i[3:0], 32'h0);
         chk(rv, 32'h0);
      end
      bus(1'h1, TCWU_OFF_COUNT, 32'h33);
      for (int i = 0; i < 7; i++)
      begin
         bus(1'h1, TCWU_OFF_CTRL, ctl(3'h0, 3'h0, fa[i], ff[i], 1'h1, 1'h0));
         bus(1'h0, TCWU_OFF_STAT, 32'h0);
         chk(rv, {29'h0, fx[i], 2'h0});
         chk(pad, fa[i] != 2'h0 ? fx[i] : 1'h0);
      end
      bus(1'h0, TCWU_OFF_COUNT, 32'h0);
      chk(rv, 32'h33);
      // Override in every mode; pad looked at once the write landed
      bus(1'h1, TCWU_OFF_CTRL, ctl(3'h0, 3'h0, 2'h3, 1'h1, 1'h1, 1'h0));
      for (int i = 0; i < 16; i++)
      begin
         bus(1'h1, TCWU_OFF_CTRL,
            ctl(md[i[3:2]], 3'h0, {i[1], 1'h0}, 1'h0, 1'h1, i[0]));
         step();
         chk(pad, i[1] ? 1'h1 : i[0]);
      end
      bus(1'h1, TCWU_OFF_CTRL, ctl(3'h0, 3'h0, 2'h2, 1'h1, 1'h0, 1'h0));
      step();
      chk({pin_oe, pad}, 32'h1);
      run(3'h0, 3'h1, 2'h1, 8'h10, 8'h00);
      meas(h, l);
      meas(h, l);
      chk(h, 256);
      chk(l, 256);
      chk({ovf, ocf}, 32'h3);
      for (int c = 1; c < 8; c++)
      begin
         run(3'h2, c[2:0], 2'h1, 8'h01, 8'h00);
         meas(h, l);
         meas(h, l);
         chk(h, 2 * nd[c]);
         chk(l, 2 * nd[c]);
         chk({ovf, ocf}, 32'h1);
      end
      run(3'h2, 3'h1, 2'h0, 8'h10, 8'h50);
      bus(1'h0, TCWU_OFF_CMPA, 32'h0);
      chk(rv, 32'h10);
      repeat (150) step();
      chk({ovf, ocf}, 32'h0);
      repeat (100) step();
      chk({ovf, ocf}, 32'h3);
      run(3'h0, 3'h1, 2'h0, 8'h10, 8'h20);
      bus(1'h1, TCWU_OFF_COUNT, 32'h10);
      repeat (100) step();
      chk(ocf, 32'h0);
      repeat (200) step();
      chk(ocf, 32'h1);
      for (int i = 0; i < 4; i++)
      begin
         run(i == 3 ? 3'h7 : 3'h3, 3'h1, pa[i], pt[i], 8'h00);
         meas(h, l);
         meas(h, l);
         chk(h, ph[i]);
         chk(l, pl[i]);
         chk(ovf, 32'h1);
      end
      // The bit left by the last test settles at the first top
      run(3'h3, 3'h1, 2'h2, 8'hFF, 8'h00);
      repeat (300) step();
      v = pad;
      n = 0;
      repeat (600)
      begin
         step();
         if (pad !== v)
            n++;
      end
      chk(n, 0);
      conclude();
   end
endmodule : tcwu_tb
`default_nettype wire
